// ### rtl/mcs_regs.svh
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH

// Register address on the serial control port
`define MCS_ADDR_CONFIG     5'h03
`define MCS_ADDR_W          5
`define MCS_REG_W           32

// Serial instruction layout
`define MCS_INSTR_READ      7
`define MCS_INSTR_ADDR_HI   4
`define MCS_INSTR_BITS      6'h08
`define MCS_FRAME_BITS      6'h28

// Field positions of multichip_sync_config
`define MCS_THRESH_HI       31
`define MCS_THRESH_LO       27
`define MCS_RX_EN           26
`define MCS_TX_EN           25
`define MCS_FIXED_LOW_A     24
`define MCS_RX_DLY_HI       23
`define MCS_RX_DLY_LO       19
`define MCS_ERR_AUTO        18
`define MCS_FIXED_LOW_B     17
`define MCS_SLAVE           16
`define MCS_TX_DLY_HI       15
`define MCS_TX_DLY_LO       11
`define MCS_FIXED_HIGH      10
`define MCS_TX_ON_FALL      9
`define MCS_LOOPBACK        8
`define MCS_CLKST_HI        7
`define MCS_CLKST_LO        4
`define MCS_WIN_HI          3
`define MCS_WIN_LO          0

// Reset value: fixed-high position set, everything else off
`define MCS_CFG_RESET       32'h0000_0400

// Sync output half period in sample clock cycles
`define MCS_SYNC_HALF       8'h10

`endif

// ### rtl/mcs_pkg.sv
`default_nettype none

package mcs_pkg;

  typedef struct packed {
    logic sclk;
    logic csN;
    logic sdi;
  } mcs_spi_in_t;

  typedef struct packed {
    logic sdo;
    logic sdoOeN;
  } mcs_spi_out_t;

  typedef struct packed {
    logic       syncOut;
    logic       syncOutOnFall;
    logic [4:0] syncOutDelay;
    logic [4:0] syncInDelay;
    logic [3:0] windowDelay;
  } mcs_sync_pins_t;

  typedef struct packed {
    logic       locked;
    logic       syncError;
    logic [3:0] clkGenState;
  } mcs_status_t;

endpackage

`default_nettype wire

// ### rtl/mcs_sync2.sv
`default_nettype none

module mcs_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] synced
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } mcs_sync_state_t;

  mcs_sync_state_t st_reg;
  mcs_sync_state_t st_next;

  always_comb begin
    st_next        = st_reg;
    st_next.stage1 = async;
    st_next.stage2 = st_reg.stage1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign synced = st_reg.stage2;

endmodule

`default_nettype wire

// ### rtl/mcs_control.sv
`include "mcs_regs.svh"
`default_nettype none

module mcs_control (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire mcs_pkg::mcs_spi_in_t   spiIn,
  output mcs_pkg::mcs_spi_out_t       spiOut,
  input  wire logic                   syncInPin,
  input  wire logic                   dataSyncPolarity,
  input  wire logic                   dataClkIn,
  output logic                        dataClkOut,
  output logic                        dataClkOeN,
  input  wire logic [15:0]            dataIn,
  output logic      [15:0]            dataLatched,
  output logic                        dataStrobe,
  output mcs_pkg::mcs_sync_pins_t     syncPins,
  output mcs_pkg::mcs_status_t        status
);

  typedef struct packed {
    logic [`MCS_REG_W-1:0] cfg;
    logic [7:0]            instr;
    logic [31:0]           shift;
    logic [5:0]            bitCnt;
    logic                  sclkPrev;
    logic                  sdo;
    logic                  sdoOeN;
    logic                  dataClkPrev;
    logic                  dataClkOut;
    logic                  dataClkOeN;
    logic [15:0]           dataLatched;
    logic                  dataStrobe;
    logic                  syncOut;
    logic [7:0]            txTimer;
    logic                  rxPrev;
    logic [7:0]            rxGap;
    logic [4:0]            runCnt;
    logic                  locked;
    logic                  checkDone;
    logic                  syncError;
    logic [3:0]            clkGenState;
    logic [3:0]            windowDelay;
  } mcs_ctl_state_t;

  mcs_ctl_state_t st_reg;
  mcs_ctl_state_t st_next;

  mcs_pkg::mcs_spi_in_t spiSync;
  logic                 syncInSync;
  logic                 dataClkSync;

  // SPI and sync pins arrive from other clocks
  mcs_sync2 #(.W(5)) u_pin_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .async   ({spiIn, syncInPin, dataClkIn}),
    .synced  ({spiSync, syncInSync, dataClkSync})
  );

  logic [15:0] dataInSync;

  // Data bus takes the same two stages as its clock, so both stay aligned
  mcs_sync2 #(.W(16)) u_data_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .async   (dataIn),
    .synced  (dataInSync)
  );

  logic       rxEn;
  logic       txEn;
  logic       slave;
  logic       rxSample;
  logic       rxEdge;
  logic       gapOk;
  logic       sclkRise;
  logic       sclkFall;
  logic       addrHit;
  logic       latchEdge;
  logic [4:0] threshold;

  always_comb begin
    rxEn      = st_reg.cfg[`MCS_RX_EN];
    txEn      = st_reg.cfg[`MCS_TX_EN];
    slave     = st_reg.cfg[`MCS_SLAVE];
    threshold = st_reg.cfg[`MCS_THRESH_HI:`MCS_THRESH_LO];
    // Own pulse replaces the pins in loopback with the driver on
    rxSample  = (txEn && st_reg.cfg[`MCS_LOOPBACK]) ? st_reg.syncOut
                                                    : syncInSync;
    rxEdge    = rxEn && (rxSample != st_reg.rxPrev);
    gapOk     = (st_reg.rxGap == (`MCS_SYNC_HALF - 8'h01));
    sclkRise  = spiSync.sclk && !st_reg.sclkPrev;
    sclkFall  = !spiSync.sclk && st_reg.sclkPrev;
    addrHit   = (st_reg.instr[`MCS_INSTR_ADDR_HI:0] == `MCS_ADDR_CONFIG);
    // Polarity zero latches on the falling edge
    latchEdge = dataSyncPolarity ? (dataClkSync && !st_reg.dataClkPrev)
                                 : (!dataClkSync && st_reg.dataClkPrev);
  end

  always_comb begin
    st_next            = st_reg;
    st_next.sclkPrev   = spiSync.sclk;
    st_next.dataStrobe = 1'b0;

    // Serial port: instruction byte, then 32 data bits, MSB first
    if (spiSync.csN) begin
      st_next.bitCnt = '0;
      st_next.sdoOeN = 1'b1;
    end else if (sclkRise && st_reg.bitCnt < `MCS_FRAME_BITS) begin
      st_next.bitCnt = st_reg.bitCnt + 6'h01;
      if (st_reg.bitCnt < `MCS_INSTR_BITS) begin
        st_next.instr = {st_reg.instr[6:0], spiSync.sdi};
      end else begin
        st_next.shift = {st_reg.shift[30:0], spiSync.sdi};
      end
      // Write commits only on a complete word; partial frames are dropped
      if (st_reg.bitCnt == `MCS_FRAME_BITS - 6'h01 &&
          !st_reg.instr[`MCS_INSTR_READ] && addrHit) begin
        st_next.cfg = {st_reg.shift[30:0], spiSync.sdi};
      end
    end else if (sclkFall && st_reg.instr[`MCS_INSTR_READ] &&
                 st_reg.bitCnt >= `MCS_INSTR_BITS &&
                 st_reg.bitCnt < `MCS_FRAME_BITS) begin
      // Unmapped addresses read back as zero
      st_next.sdoOeN = 1'b0;
      st_next.sdo    = addrHit ?
        st_reg.cfg[5'(`MCS_FRAME_BITS - 6'h01 - st_reg.bitCnt)] : 1'b0;
    end

    // Data clock pin: driven in master mode, input in slave mode
    st_next.dataClkOeN  = slave;
    st_next.dataClkOut  = slave ? 1'b0 : !st_reg.dataClkOut;
    st_next.dataClkPrev = dataClkSync;
    if (slave && latchEdge) begin
      st_next.dataLatched = dataInSync;
      st_next.dataStrobe  = 1'b1;
    end

    // Output pulse generator
    if (txEn) begin
      if (st_reg.txTimer == `MCS_SYNC_HALF - 8'h01) begin
        st_next.txTimer = '0;
        st_next.syncOut = !st_reg.syncOut;
      end else begin
        st_next.txTimer = st_reg.txTimer + 8'h01;
      end
    end else begin
      st_next.txTimer = '0;
      st_next.syncOut = 1'b0;
    end

    // Window delay word only matters with the driver on
    st_next.windowDelay = txEn ? st_reg.cfg[`MCS_WIN_HI:`MCS_WIN_LO]
                               : 4'h0;

    // Free-running clock generator, reloaded on synchronization
    st_next.clkGenState = st_reg.clkGenState + 4'h1;

    // Receiver: correlate edge spacing against the expected half period
    if (!rxEn) begin
      st_next.rxPrev    = 1'b0;
      st_next.rxGap     = '0;
      st_next.runCnt    = '0;
      st_next.locked    = 1'b0;
      st_next.checkDone = 1'b0;
      st_next.syncError = 1'b0;
    end else begin
      st_next.rxPrev = rxSample;
      st_next.rxGap  = (rxEdge || st_reg.rxGap == 8'hFF) ? 8'h00
                                                          : st_reg.rxGap + 8'h01;
      if (rxEdge && !st_reg.locked) begin
        if (!gapOk) begin
          st_next.runCnt = '0;
        end else if (st_reg.runCnt >= threshold) begin
          st_next.locked      = 1'b1;
          st_next.clkGenState = st_reg.cfg[`MCS_CLKST_HI:`MCS_CLKST_LO];
        end else begin
          st_next.runCnt = st_reg.runCnt + 5'h01;
        end
      end else if (rxEdge && st_reg.locked) begin
        // Manual mode checks one edge; automatic keeps checking
        if (st_reg.cfg[`MCS_ERR_AUTO] || !st_reg.checkDone) begin
          st_next.checkDone = 1'b1;
          if (!gapOk) begin
            st_next.syncError = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg            <= '0;
      st_reg.cfg        <= `MCS_CFG_RESET;
      st_reg.sdoOeN     <= 1'b1;
      st_reg.dataClkOeN <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    spiOut.sdo            = st_reg.sdo;
    spiOut.sdoOeN         = st_reg.sdoOeN;
    dataClkOut            = st_reg.dataClkOut;
    dataClkOeN            = st_reg.dataClkOeN;
    dataLatched           = st_reg.dataLatched;
    dataStrobe            = st_reg.dataStrobe;
    syncPins.syncOut      = st_reg.syncOut;
    // Pad cell retimes on the falling edge when set
    syncPins.syncOutOnFall = st_reg.cfg[`MCS_TX_ON_FALL];
    syncPins.syncOutDelay = st_reg.cfg[`MCS_TX_DLY_HI:`MCS_TX_DLY_LO];
    syncPins.syncInDelay  = st_reg.cfg[`MCS_RX_DLY_HI:`MCS_RX_DLY_LO];
    syncPins.windowDelay  = st_reg.windowDelay;
    status.locked         = st_reg.locked;
    status.syncError      = st_reg.syncError;
    status.clkGenState    = st_reg.clkGenState;
  end

endmodule

`default_nettype wire

// ### dv/mcs_control_assertions.sv
`default_nettype none
module mcs_control_assertions (
  input wire logic                    clk_sys,
  input wire logic                    rst,
  input wire logic                    dataSyncPolarity,
  input wire logic                    dataClkIn,
  input wire logic                    dataClkOut,
  input wire logic                    dataClkOeN,
  input wire logic [15:0]             dataIn,
  input wire logic [15:0]             dataLatched,
  input wire logic                    dataStrobe,
  input wire mcs_pkg::mcs_sync_pins_t syncPins,
  input wire mcs_pkg::mcs_status_t    status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  chk_pin_input: assert property (dataClkOeN |-> !dataClkOut)
    else $error("data clock driven while input");
  chk_master_toggle: assert property (!dataClkOeN && !$past(dataClkOeN)
    && !$past(rst) |-> dataClkOut != $past(dataClkOut))
    else $error("master clock stalled");
  chk_latch_slave: assert property (dataStrobe |-> dataClkOeN)
    else $error("latch outside slave mode");
  chk_latch_value: assert property (
    dataStrobe |-> dataLatched == $past(dataIn, 3)) else $error("latched word");
  chk_latch_edge: assert property (
    dataStrobe |-> dataClkIn == dataSyncPolarity) else $error("latch edge");
  chk_sync_half: assert property (
    $rose(syncPins.syncOut) |-> ##16 $fell(syncPins.syncOut))
    else $error("sync half period");
  chk_err_sticky: assert property (
    status.syncError |=> status.syncError || !status.locked)
    else $error("sync error dropped");
  chk_err_lock: assert property (
    $rose(status.syncError) |-> $past(status.locked))
    else $error("sync error before lock");
  cover property ($rose(status.locked));
  cover property (dataStrobe && dataSyncPolarity);
  cover property ($rose(status.syncError));
endmodule

bind mcs_control mcs_control_assertions chk (.clk_sys(clk_sys), .rst(rst),
  .dataSyncPolarity(dataSyncPolarity), .dataClkIn(dataClkIn),
  .dataClkOut(dataClkOut), .dataClkOeN(dataClkOeN), .dataIn(dataIn),
  .dataLatched(dataLatched), .dataStrobe(dataStrobe), .syncPins(syncPins),
  .status(status));
`default_nettype wire

// ### dv/mcs_host_model.sv
`default_nettype none
module mcs_host_model (
  input  wire logic                  clk_sys,
  output var  mcs_pkg::mcs_spi_in_t  spiIn,
  input  wire mcs_pkg::mcs_spi_out_t spiOut
);
  timeunit 1ns;
  timeprecision 1ps;
  initial spiIn = 3'h2;
  task automatic xfer(input logic rdOp, input logic [4:0] a,
    input logic [31:0] wd, output logic [31:0] q);
    logic [39:0] f;
    f = {rdOp, 2'h0, a, wd & 32'hFEFD_FFFF | 32'h0000_0400};
    q = 32'h0;
    spiIn.csN = 1'b0;
    for (int i = 0; i < 40; i++) begin
      spiIn.sdi = f[39-i];
      repeat (4) @(negedge clk_sys);
      if (i > 7) q[39-i] = spiOut.sdo & ~spiOut.sdoOeN;
      spiIn.sclk = 1'b1;
      repeat (4) @(negedge clk_sys);
      spiIn.sclk = 1'b0;
    end
    repeat (4) @(negedge clk_sys);
    spiIn.csN = 1'b1;
    // Released line must not keep the last bit
    spiIn.sdi = ~spiIn.sdi;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ### dv/multichip_sync_control_test.sv
`include "mcs_regs.svh"
`default_nettype none
module multichip_sync_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst, syncInPin, dataSyncPolarity, extClk, noise;
  logic        dataClkOut, dataClkOeN, dataStrobe;
  logic [15:0] dataIn, dataLatched, expQ[$];
  logic [31:0] v, rd, seed = 32'h0000_0048;
  int          n, err_total = 0, checked = 0;
  mcs_pkg::mcs_spi_in_t    spiIn;
  mcs_pkg::mcs_spi_out_t   spiOut;
  mcs_pkg::mcs_sync_pins_t syncPins;
  mcs_pkg::mcs_status_t    status;
  wire logic   dataClkPin = dataClkOeN ? extClk : dataClkOut;

  mcs_control dut (.clk_sys(clk_sys), .rst(rst), .spiIn(spiIn),
    .spiOut(spiOut), .syncInPin(syncInPin),
    .dataSyncPolarity(dataSyncPolarity), .dataClkIn(dataClkPin),
    .dataClkOut(dataClkOut), .dataClkOeN(dataClkOeN), .dataIn(dataIn),
    .dataLatched(dataLatched), .dataStrobe(dataStrobe),
    .syncPins(syncPins), .status(status));
  mcs_host_model host (.clk_sys(clk_sys), .spiIn(spiIn), .spiOut(spiOut));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cfg(logic [31:0] x);
    host.xfer(1'b0, `MCS_ADDR_CONFIG, x, rd);
  endtask
  task automatic edges(int k, int gap);
    repeat (k) begin
      repeat (gap) @(negedge clk_sys);
      syncInPin = ~syncInPin;
    end
    repeat (4) @(negedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Strobes at slave entry may latch a stale master edge, so unqueued ones pass
  always @(negedge clk_sys) begin
    if (noise === 1'b1) syncInPin = ~syncInPin;
    if (dataStrobe === 1'b1 && expQ.size() > 0)
      chk("latched", 32'(expQ.pop_front()), 32'(dataLatched));
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    $display("unexpected watchdog: expected finish seen timeout");
    results();
  end

  initial begin
    rst = 1'b1;
    noise = 1'b0;
    syncInPin = 1'b0;
    dataSyncPolarity = 1'b0;
    extClk = 1'b0;
    dataIn = 16'h0000;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    host.xfer(1'b1, `MCS_ADDR_CONFIG, 32'h0, rd);
    chk("reset value", `MCS_CFG_RESET, rd);
    host.xfer(1'b1, 5'h05, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    for (int i = 0; i < 4; i++) begin
      v = rnd() & 32'hF8FD_FFFF | 32'h0000_0400;
      cfg(v);
      host.xfer(1'b1, `MCS_ADDR_CONFIG, 32'h0, rd);
      chk("readback", v, rd);
      chk("in delay", 32'(v[23:19]), 32'(syncPins.syncInDelay));
      chk("out delay", 32'(v[15:11]), 32'(syncPins.syncOutDelay));
      chk("out edge", 32'(v[9]), 32'(syncPins.syncOutOnFall));
      chk("window off", 32'h0, 32'(syncPins.windowDelay));
      chk("pin input", 32'(v[16]), 32'(dataClkOeN));
    end
    $display("test registers done");
    for (int p = 0; p < 2; p++) begin
      dataSyncPolarity = p[0];
      extClk = p[0];
      cfg(32'h0001_0400);
      repeat (4) begin
        extClk = ~p[0];
        repeat (6) @(negedge clk_sys);
        v = rnd();
        dataIn = v[15:0];
        expQ.push_back(v[15:0]);
        repeat (3) @(negedge clk_sys);
        extClk = p[0];
        repeat (6) @(negedge clk_sys);
      end
      chk("unlatched", 32'h0, 32'(expQ.size()));
    end
    $display("test data port done");
    noise = 1'b1;
    cfg(32'h1604_05A5);
    n = 0;
    while (status.locked !== 1'b1 && n < 500) begin
      @(negedge clk_sys);
      n++;
    end
    chk("lock time", 32'h1, 32'(n >= 32 && n < 500));
    chk("clock state", 32'hA, 32'(status.clkGenState));
    chk("window on", 32'h5, 32'(syncPins.windowDelay));
    repeat (100) @(negedge clk_sys);
    chk("loop error", 32'h0, 32'(status.syncError));
    noise = 1'b0;
    cfg(32'h1204_05A5);
    chk("rx off", 32'h0, 32'({status.locked, status.syncError}));
    $display("test loopback done");
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    for (int m = 0; m < 2; m++) begin
      v = 32'h0C00_0400;
      v[18] = m[0];
      cfg(v);
      edges(6, 16);
      chk("ext lock", 32'h1, 32'(status.locked));
      edges(1, 7);
      chk("sync error", 32'(m), 32'(status.syncError));
      cfg(32'h0000_0400);
    end
    $display("test error check done");
    results();
  end
endmodule
`default_nettype wire
